// *** verilog/crem_pkg.sv ***
package crem_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ERR_CNT   = 8'h5c;
  localparam logic [7:0] IDX_ERR_FLAGS = 8'h5d;
  localparam logic [7:0] IDX_LANE01    = 8'h5e;
  localparam logic [7:0] IDX_LANE23    = 8'h5f;
  localparam logic [7:0] IDX_CLK_LANE  = 8'h60;
  localparam logic [7:0] IDX_HDR_VC_DT = 8'h61;
  localparam logic [7:0] IDX_WC_LO     = 8'h62;
  localparam logic [7:0] IDX_WC_HI     = 8'h63;
  localparam logic [7:0] IDX_ECC       = 8'h64;
  localparam logic [7:0] IDX_CTRL      = 8'h40;

  localparam int unsigned ADDR_IDX_LSB = 2;
  localparam int unsigned ADDR_IDX_MSB = 9;

  // packet-level flag positions
  localparam int unsigned FLG_SHORT  = 3;
  localparam int unsigned FLG_CKSUM  = 2;
  localparam int unsigned FLG_DOUBLE = 1;
  localparam int unsigned FLG_SINGLE = 0;

  // per-lane nibble layout; odd lane in the upper nibble
  localparam int unsigned NIB_SINGLE = 3;
  localparam int unsigned NIB_MULTI  = 2;
  localparam int unsigned NIB_HS     = 1;
  localparam int unsigned CLK_HS_BIT = 1;
  localparam int unsigned LEN_CHG_BIT = 7;
  localparam int unsigned CTRL_EN_BIT = 0;

  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hff;
  localparam logic [7:0] CNT_ONE   = 8'h01;
  localparam logic [7:0] CTRL_RST  = 8'h01;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // one sample of the receive front end, valid per link clock rising edge
  typedef struct packed {
    logic       hdr_valid;
    logic       hdr_long;
    logic [1:0] vc;
    logic [5:0] dt;
    logic [15:0] wc;
    logic [5:0] ecc;
    logic       pkt_end;
    logic       short_line;
    logic       cksum_fail;
    logic       hdr_double;
    logic       hdr_single;
    logic [3:0] sot_single;
    logic [3:0] sot_multi;
    logic [3:0] hs_fault;
    logic       clk_hs_fault;
    logic       len_change;
  } crem_evt_t;

endpackage : crem_pkg

// *** verilog/crem_sync3.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; a bit is accepted once stages two and three agree
module crem_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // holding on disagreement filters a single-sample glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
    end
  end

endmodule : crem_sync3

// *** verilog/crem_sticky.sv ***
`timescale 1ns/1ps
// sticky flags; a set in the clearing cycle survives the clear
module crem_sticky #(
  parameter int unsigned W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] q
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & ~{W{clr}}) | set;
    end
  end

endmodule : crem_sticky

// *** verilog/crem_monitor.sv ***
`timescale 1ns/1ps
module crem_monitor (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  input  wire logic                rx_link_clk,
  input  wire crem_pkg::crem_evt_t rx_evt
);

  localparam int unsigned SW = $bits(crem_pkg::crem_evt_t) + 1;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:crem_pkg::ADDR_IDX_MSB+1] == '0) && (a[crem_pkg::ADDR_IDX_LSB-1:0] == '0)
          && (a[crem_pkg::ADDR_IDX_MSB:crem_pkg::ADDR_IDX_LSB] == idx);
  endfunction : hit

  function automatic logic [3:0] lane_nib(input logic s, input logic m, input logic h);
    lane_nib = '0;
    lane_nib[crem_pkg::NIB_SINGLE] = s;
    lane_nib[crem_pkg::NIB_MULTI]  = m;
    lane_nib[crem_pkg::NIB_HS]     = h;
  endfunction : lane_nib

  logic [SW-1:0]        sync_lvl;
  crem_pkg::crem_evt_t  evt;
  logic                 link_lvl;
  logic                 link_prev_q;
  logic                 link_rise;
  logic                 ev_ok;
  logic [7:0]           ctrl_q;
  logic                 wr_pend_q;
  logic [31:0]          wr_addr_q;
  logic [7:0]           cnt_q;
  logic [7:0]           cnt_d;
  logic                 cnt_inc;
  logic [7:0]           flags_set;
  logic [7:0]           flags_q;
  logic [7:0]           lane01_q;
  logic [7:0]           lane23_q;
  logic [7:0]           clk_set;
  logic [7:0]           clk_q;
  logic [7:0]           len_q;
  logic [7:0]           len_set;
  logic [7:0]           vcdt_q;
  logic [15:0]          wc_q;
  logic [5:0]           ecc_q;
  logic                 take;
  logic                 rd_take;
  logic [7:0]           rd_val;
  logic                 clr_cnt;
  logic                 clr_flags;
  logic                 clr_l01;
  logic                 clr_l23;
  logic                 clr_clk;
  logic                 clr_ecc;

  // the link clock and its data cross on the same synchroniser, so they stay aligned
  crem_sync3 #(
    .W (SW)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({rx_link_clk, rx_evt}),
    .q       (sync_lvl)
  );

  assign link_lvl = sync_lvl[SW-1];
  assign evt      = sync_lvl[SW-2:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_prev_q <= 1'b0;
    end else if (ce) begin
      link_prev_q <= link_lvl;
    end
  end

  assign link_rise = link_lvl & ~link_prev_q;
  assign ev_ok     = link_rise & ctrl_q[crem_pkg::CTRL_EN_BIT];

  // bus slave: zero wait state unless the clock enable is low
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign take      = hsel & (htrans == crem_pkg::HTRANS_NONSEQ) & hready & ce;
  assign rd_take   = take & ~hwrite;

  assign clr_cnt   = rd_take & hit(haddr, crem_pkg::IDX_ERR_CNT);
  assign clr_flags = rd_take & hit(haddr, crem_pkg::IDX_ERR_FLAGS);
  assign clr_l01   = rd_take & hit(haddr, crem_pkg::IDX_LANE01);
  assign clr_l23   = rd_take & hit(haddr, crem_pkg::IDX_LANE23);
  assign clr_clk   = rd_take & hit(haddr, crem_pkg::IDX_CLK_LANE);
  assign clr_ecc   = rd_take & hit(haddr, crem_pkg::IDX_ECC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (ce) begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= haddr;
    end
  end

  // control byte; clearing the enable bit stops all capture and counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= crem_pkg::CTRL_RST;
    end else if (ce && wr_pend_q && hit(wr_addr_q, crem_pkg::IDX_CTRL)) begin
      ctrl_q <= hwdata[7:0];
    end
  end

  always_comb begin
    rd_val = crem_pkg::RST_BYTE;
    if (hit(haddr, crem_pkg::IDX_ERR_CNT))   rd_val = cnt_q;
    if (hit(haddr, crem_pkg::IDX_ERR_FLAGS)) rd_val = flags_q;
    if (hit(haddr, crem_pkg::IDX_LANE01))    rd_val = lane01_q;
    if (hit(haddr, crem_pkg::IDX_LANE23))    rd_val = lane23_q;
    if (hit(haddr, crem_pkg::IDX_CLK_LANE))  rd_val = clk_q;
    if (hit(haddr, crem_pkg::IDX_HDR_VC_DT)) rd_val = vcdt_q;
    if (hit(haddr, crem_pkg::IDX_WC_LO))     rd_val = wc_q[7:0];
    if (hit(haddr, crem_pkg::IDX_WC_HI))     rd_val = wc_q[15:8];
    if (hit(haddr, crem_pkg::IDX_ECC))       rd_val = len_q | {2'h0, ecc_q};
    if (hit(haddr, crem_pkg::IDX_CTRL))      rd_val = ctrl_q;
  end

  // read data is caught at the address phase, before the read clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_take) begin
      hrdata <= {24'h0, rd_val};
    end
  end

  // errored packet counter
  assign cnt_inc = ev_ok & evt.pkt_end
                   & (evt.short_line | evt.cksum_fail | evt.hdr_double | evt.hdr_single);

  always_comb begin
    cnt_d = clr_cnt ? crem_pkg::RST_BYTE : cnt_q;
    if (cnt_inc) begin
      cnt_d = clr_cnt ? crem_pkg::CNT_ONE
            : (cnt_q == crem_pkg::CNT_MAX) ? crem_pkg::CNT_MAX : cnt_q + crem_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= crem_pkg::RST_BYTE;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    flags_set = '0;
    flags_set[crem_pkg::FLG_SHORT]  = ev_ok & evt.short_line;
    flags_set[crem_pkg::FLG_CKSUM]  = ev_ok & evt.cksum_fail;
    flags_set[crem_pkg::FLG_DOUBLE] = ev_ok & evt.hdr_double;
    flags_set[crem_pkg::FLG_SINGLE] = ev_ok & evt.hdr_single;
    clk_set = '0;
    clk_set[crem_pkg::CLK_HS_BIT] = ev_ok & evt.clk_hs_fault;
    len_set = '0;
    len_set[crem_pkg::LEN_CHG_BIT] = ev_ok & evt.len_change;
  end

  crem_sticky #(.W (8)) u_flags (
    .hclk (hclk), .hresetn (hresetn), .ce (ce), .set (flags_set), .clr (clr_flags), .q (flags_q)
  );

  crem_sticky #(.W (8)) u_lane01 (
    .hclk (hclk), .hresetn (hresetn), .ce (ce), .clr (clr_l01), .q (lane01_q),
    .set  ({8{ev_ok}} & {lane_nib(evt.sot_single[1], evt.sot_multi[1], evt.hs_fault[1]),
                         lane_nib(evt.sot_single[0], evt.sot_multi[0], evt.hs_fault[0])})
  );

  crem_sticky #(.W (8)) u_lane23 (
    .hclk (hclk), .hresetn (hresetn), .ce (ce), .clr (clr_l23), .q (lane23_q),
    .set  ({8{ev_ok}} & {lane_nib(evt.sot_single[3], evt.sot_multi[3], evt.hs_fault[3]),
                         lane_nib(evt.sot_single[2], evt.sot_multi[2], evt.hs_fault[2])})
  );

  crem_sticky #(.W (8)) u_clk (
    .hclk (hclk), .hresetn (hresetn), .ce (ce), .set (clk_set), .clr (clr_clk), .q (clk_q)
  );

  crem_sticky #(.W (8)) u_len (
    .hclk (hclk), .hresetn (hresetn), .ce (ce), .set (len_set), .clr (clr_ecc), .q (len_q)
  );

  // header capture; newest long header always overwrites
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vcdt_q <= crem_pkg::RST_BYTE;
      wc_q   <= '0;
    end else if (ce && ev_ok && evt.hdr_valid && evt.hdr_long) begin
      vcdt_q <= {evt.vc, evt.dt};
      wc_q   <= evt.wc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ecc_q <= '0;
    end else if (ce && ev_ok && evt.hdr_valid) begin
      ecc_q <= evt.ecc;
    end
  end

  logic [7:0] hdr_in;
  assign hdr_in = {evt.vc, evt.dt};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cnt_read;
    rd_take && hit(haddr, crem_pkg::IDX_ERR_CNT);
  endsequence

  sequence s_long_hdr;
    ce && ev_ok && evt.hdr_valid && evt.hdr_long;
  endsequence

  // a packet that lands on the clearing read still counts as the first one
  AST_CNT_READ_CLEARS: assert property (s_cnt_read
    |=> cnt_q == ($past(cnt_inc) ? crem_pkg::CNT_ONE : crem_pkg::RST_BYTE))
    else $error("count not cleared by read");

  AST_CNT_READ_DATA: assert property (s_cnt_read |=> hrdata[7:0] == $past(cnt_q))
    else $error("count read returned wrong value");

  AST_CNT_STEP: assert property (ce && cnt_inc && !clr_cnt && cnt_q != crem_pkg::CNT_MAX
    |=> cnt_q == $past(cnt_q) + crem_pkg::CNT_ONE)
    else $error("count did not step by one");

  AST_CNT_SATURATE: assert property (ce && cnt_q == crem_pkg::CNT_MAX && !clr_cnt
    |=> cnt_q == crem_pkg::CNT_MAX)
    else $error("count left its maximum");

  AST_SHORT_FLAG: assert property (ce && ev_ok && evt.short_line |=> flags_q[crem_pkg::FLG_SHORT])
    else $error("short line flag not set");

  AST_CKSUM_FLAG: assert property (ce && ev_ok && evt.cksum_fail |=> flags_q[crem_pkg::FLG_CKSUM])
    else $error("checksum flag not set");

  AST_DOUBLE_FLAG: assert property (ce && ev_ok && evt.hdr_double |=> flags_q[crem_pkg::FLG_DOUBLE])
    else $error("double fault flag not set");

  AST_SINGLE_FLAG: assert property (ce && ev_ok && evt.hdr_single |=> flags_q[crem_pkg::FLG_SINGLE])
    else $error("single fault flag not set");

  AST_FLAGS_HOLD: assert property (ce && !clr_flags |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("status flag dropped without a read");

  AST_LANE1_MAP: assert property (ce && ev_ok && evt.sot_single[1] && evt.hs_fault[0]
    |=> lane01_q[crem_pkg::NIB_SINGLE+4] && lane01_q[crem_pkg::NIB_HS])
    else $error("lane one/zero flags misplaced");

  AST_LANE3_MAP: assert property (ce && ev_ok && evt.sot_multi[3] |=> lane23_q[crem_pkg::NIB_MULTI+4])
    else $error("lane three multi fault misplaced");

  // reserved bits must read zero whenever the flag is raised
  AST_CLK_LANE: assert property (ce && ev_ok && evt.clk_hs_fault
    |=> clk_q == (crem_pkg::CNT_ONE << crem_pkg::CLK_HS_BIT))
    else $error("clock lane flag wrong");

  AST_HDR_CAPTURE: assert property (s_long_hdr |=> vcdt_q == $past(hdr_in) ##1 1'b1)
    else $error("header channel and type not captured");

  AST_WC_CAPTURE: assert property (s_long_hdr |=> wc_q[7:0] == $past(evt.wc[7:0])
    && wc_q[15:8] == $past(evt.wc[15:8]))
    else $error("word count not captured");

  AST_LEN_CHANGE: assert property (ce && ev_ok && evt.len_change |=> len_q[crem_pkg::LEN_CHG_BIT])
    else $error("line length change not flagged");

  AST_ECC_CAPTURE: assert property (ce && ev_ok && evt.hdr_valid |=> ecc_q == $past(evt.ecc))
    else $error("header correction byte not captured");

endmodule : crem_monitor

// *** test/crem_sensor_model.sv ***
`timescale 1ns/1ps
// behavioural sensor front end; the link clock only moves while a sample is sent
module crem_sensor_model (
  output logic                rx_link_clk,
  output crem_pkg::crem_evt_t rx_evt
);
  initial begin
    rx_link_clk = 1'b0;
    rx_evt      = '0;
  end

  // sample held a full link period around its rising edge
  task automatic send(input crem_pkg::crem_evt_t e);
    rx_evt = e;
    #80;
    rx_link_clk = 1'b1;
    #80;
    rx_link_clk = 1'b0;
    // released lines show the inverse, harmless while the clock stands still
    rx_evt = ~e;
  endtask : send
endmodule : crem_sensor_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic                hclk;
  logic                hresetn;
  logic                ce;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hready;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic                rx_link_clk;
  crem_pkg::crem_evt_t rx_evt;
  crem_pkg::crem_evt_t ev;
  logic [31:0]         rd;
  int                  mismatches;
  int                  total_checks;

  assign hready = hreadyout;

  crem_monitor i_crem_monitor (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata),
    .rx_link_clk(rx_link_clk),
    .rx_evt     (rx_evt)
  );

  crem_sensor_model i_crem_sensor_model (
    .rx_link_clk(rx_link_clk),
    .rx_evt     (rx_evt)
  );

  always #4 hclk = ~hclk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        mismatches++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= crem_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    bus(idx, 1'b0, 32'h0);
    check(rd, {24'h0, e});
  endtask : rc

  // edge lands on an hclk rising edge, so wait one hclk edge before the next bus call
  task automatic pulse(input crem_pkg::crem_evt_t e);
    i_crem_sensor_model.send(e);
    @(posedge hclk);
  endtask : pulse

  task automatic hdr(input logic lng, input logic [1:0] vc, input logic [5:0] dt,
                     input logic [15:0] wc, input logic [5:0] ecc, input logic chg);
    ev = '0;
    ev.hdr_valid = 1'b1;
    ev.hdr_long = lng;
    ev.vc = vc;
    ev.dt = dt;
    ev.wc = wc;
    ev.ecc = ecc;
    ev.len_change = chg;
    pulse(ev);
  endtask : hdr

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values; 0x65 is unmapped, write to a read-only place is ignored
    for (int i = 'h5c; i <= 'h65; i++) rc(8'(i), 8'h00);
    rc(crem_pkg::IDX_CTRL, crem_pkg::CTRL_RST);
    bus(crem_pkg::IDX_ERR_CNT, 1'b1, 32'h55);
    rc(crem_pkg::IDX_ERR_CNT, 8'h00);
    check({31'h0, hresp}, 32'h0);
    $display("test reset done");
    // each packet fault alone, sticky until read, each packet counted
    for (int b = 0; b < 4; b++) begin
      ev = '0;
      ev.pkt_end = 1'b1;
      {ev.short_line, ev.cksum_fail, ev.hdr_double, ev.hdr_single} = 4'(1 << b);
      pulse(ev);
      rc(crem_pkg::IDX_ERR_FLAGS, 8'(1 << b));
      rc(crem_pkg::IDX_ERR_FLAGS, 8'h00);
    end
    rc(crem_pkg::IDX_ERR_CNT, 8'h04);
    rc(crem_pkg::IDX_ERR_CNT, 8'h00);
    $display("test packet flags done");
    for (int l = 0; l < 4; l++) begin
      for (int k = 0; k < 3; k++) begin
        ev = '0;
        ev.sot_single[l] = (k == 0);
        ev.sot_multi[l] = (k == 1);
        ev.hs_fault[l] = (k == 2);
        pulse(ev);
        rc(l < 2 ? crem_pkg::IDX_LANE01 : crem_pkg::IDX_LANE23, 8'(1 << (3 - k + 4 * (l % 2))));
      end
    end
    ev = '0;
    ev.sot_single = 4'hf;
    ev.sot_multi = 4'hf;
    ev.hs_fault = 4'hf;
    ev.clk_hs_fault = 1'b1;
    pulse(ev);
    rc(crem_pkg::IDX_LANE01, 8'hee);
    rc(crem_pkg::IDX_LANE23, 8'hee);
    rc(crem_pkg::IDX_CLK_LANE, 8'h02);
    $display("test lanes done");
    hdr(1'b1, 2'h2, 6'h2b, 16'h1234, 6'h15, 1'b0);
    rc(crem_pkg::IDX_HDR_VC_DT, 8'hab);
    rc(crem_pkg::IDX_WC_LO, 8'h34);
    rc(crem_pkg::IDX_WC_HI, 8'h12);
    rc(crem_pkg::IDX_ECC, 8'h15);
    hdr(1'b1, 2'h1, 6'h1e, 16'ha5c3, 6'h2a, 1'b1);
    rc(crem_pkg::IDX_HDR_VC_DT, 8'h5e);
    rc(crem_pkg::IDX_WC_LO, 8'hc3);
    rc(crem_pkg::IDX_WC_HI, 8'ha5);
    rc(crem_pkg::IDX_ECC, 8'haa);
    // a short header must not disturb the long-header captures
    hdr(1'b0, 2'h3, 6'h3f, 16'hffff, 6'h07, 1'b0);
    rc(crem_pkg::IDX_HDR_VC_DT, 8'h5e);
    rc(crem_pkg::IDX_WC_HI, 8'ha5);
    rc(crem_pkg::IDX_ECC, 8'h07);
    $display("test headers done");
    ev = '0;
    ev.pkt_end = 1'b1;
    ev.cksum_fail = 1'b1;
    repeat (257) pulse(ev);
    rc(crem_pkg::IDX_ERR_CNT, 8'hff);
    rc(crem_pkg::IDX_ERR_CNT, 8'h00);
    rc(crem_pkg::IDX_ERR_FLAGS, 8'h04);
    $display("test saturation done");
    // capture disabled: faults are ignored
    bus(crem_pkg::IDX_CTRL, 1'b1, 32'h0);
    rc(crem_pkg::IDX_CTRL, 8'h00);
    pulse(ev);
    rc(crem_pkg::IDX_ERR_FLAGS, 8'h00);
    rc(crem_pkg::IDX_ERR_CNT, 8'h00);
    bus(crem_pkg::IDX_CTRL, 1'b1, 32'h1);
    rc(crem_pkg::IDX_CTRL, 8'h01);
    ce <= 1'b0;
    @(posedge hclk);
    check({31'h0, hreadyout}, 32'h0);
    ce <= 1'b1;
    @(posedge hclk);
    $display("test control done");
    summarize();
  end
endmodule : tb
